/* bsp_pkg.sv */
// Constants shared by the burst SRAM port logic
// Summary of operation
// [R1] Valid flag marks driven read data
// [R2] Termination range latched at power-up
// [R3] Floating range pin means high range
// [R4] Accesses start only on K rise
// [R5] K rise samples inputs, launches word
// [R6] K-bar rise captures/launches other word
// [R7] Echo clocks free-run with input clocks; the code holds them while clk_en_i is low
// [R8] Grounded PLL pin selects legacy mode
// [R9] Controller keeps clocks slow in legacy mode
// [R10] PLL on: data 2.5 cycles later
// [R11] PLL off: data one cycle later
// [R12] Data inputs registered on both clocks
// [R13] Data outputs registered on both clocks
// [R14] Load and direction sampled on K only
// [R15] Load low: direction high reads, low writes
// [R16] Every access is a two-word burst
// [R17] Byte selects guard 9-bit lanes
// [R18] Outputs float when no read active
// [R19] Valid flag low without read beat
package bsp_pkg;
   localparam int DATA_W = 36;
   localparam int LANE_W = 9;
   localparam int LANES = 4;
   localparam int ADDR_W = 21;
   localparam int IDX_W = 4;
   localparam int MEM_WORDS = 16;
   localparam int BURST = 2;
   localparam int FIFO_DEPTH = 8;
   // Entry: index, beat, lane selects, data
   localparam int WENT_W = IDX_W + 1 + LANES + DATA_W;
   localparam int PIN_W = 3 + LANES + ADDR_W + DATA_W + 4;
   localparam logic [1:0] STRAP_WAIT = 2'h3;
   localparam logic TERM_RST = 1'b1;
endpackage : bsp_pkg

/* bsp_port.sv */
// Burst SRAM port: write buffer and pin-facing core
`timescale 1ns/1ps
`default_nettype none

module bsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int PW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   logic push;
   logic pop;

   // Honest levels straight from the count
   assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rp_q];
   assign push = clk_en_i & in_valid_i & in_ready_o;
   assign pop = clk_en_i & out_valid_o & out_ready_i;

   // Storage needs no reset, pointers guard it
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_q[wp_q] <= in_data_i;
      end
   end

   // Pointers and fill count
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= wp_q + 1'b1;
         end
         if (pop) begin
            rp_q <= rp_q + 1'b1;
         end
         cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule : bsp_fifo

module bsp_port (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic clk_en_i,
   input wire logic k_clk_i,
   input wire logic k_clk_n_i,
   input wire logic load_strobe_n_i,
   input wire logic rw_sel_i,
   input wire logic [bsp_pkg::ADDR_W-1:0] addr_i,
   input wire logic [bsp_pkg::LANES-1:0] byte_write_sel_n_i,
   input wire logic [bsp_pkg::DATA_W-1:0] dq_i,
   input wire logic termination_range_select_i,
   input wire logic termination_range_float_i,
   input wire logic pll_disable_pin_n_i,
   output logic [bsp_pkg::DATA_W-1:0] dq_o,
   output logic dq_oe_o,
   output logic read_valid_flag_o,
   output logic echo_out_pos_o,
   output logic echo_out_neg_o,
   output logic term_range_high_o,
   output logic pll_off_o
);
   import bsp_pkg::*;

   logic [PIN_W-1:0] pin_s1_q;
   logic [PIN_W-1:0] pin_s2_q;
   logic k_s, kn_s, ld_n_s, rw_s, term_s, tz_s, pll_disable_pin_n_s;
   logic [LANES-1:0] bws_n_s;
   logic [ADDR_W-1:0] addr_s;
   logic [DATA_W-1:0] dq_s;
   logic k_s3_q;
   logic kn_s3_q;
   logic kr;
   logic knr;
   logic [1:0] strap_cnt_q;
   logic strap_done_q;
   logic cmd;
   logic rd_cmd;
   logic wr_cmd;
   logic [1:0] rd_pipe_q;
   logic [IDX_W-1:0] ra0_q;
   logic [IDX_W-1:0] ra1_q;
   logic wr_b0_q;
   logic wr_b1_q;
   logic [IDX_W-1:0] wa_q;
   logic [IDX_W-1:0] wa1_q;
   logic push_v;
   logic [WENT_W-1:0] push_d;
   logic fifo_rdy;
   logic pop_v;
   logic pop_rdy;
   logic [WENT_W-1:0] pop_d;
   logic [DATA_W-1:0] mem_q [MEM_WORDS][BURST];
   logic pend_b0_kn_q;
   logic pend_b1_k_q;
   logic pend_b1_kn_q;
   logic [IDX_W-1:0] raddr_q;

   // Every pin crosses two flops; all share one delay
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
      end else if (clk_en_i) begin
         pin_s1_q <= {k_clk_i, k_clk_n_i, load_strobe_n_i, rw_sel_i,
                      byte_write_sel_n_i, addr_i, dq_i,
                      termination_range_select_i,
                      termination_range_float_i, pll_disable_pin_n_i};
         pin_s2_q <= pin_s1_q;
      end
   end

   assign {k_s, kn_s, ld_n_s, rw_s, bws_n_s, addr_s, dq_s, term_s, tz_s,
           pll_disable_pin_n_s} = pin_s2_q;

   // Edge finders and echo clocks, running whenever clk_en_i is high
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         k_s3_q <= 1'b0;
         kn_s3_q <= 1'b0;
         echo_out_pos_o <= 1'b0;
         echo_out_neg_o <= 1'b0;
      end else if (clk_en_i) begin
         k_s3_q <= k_s;
         kn_s3_q <= kn_s;
         echo_out_pos_o <= k_s; // [R7]
         echo_out_neg_o <= kn_s; // [R7]
      end
   end

   assign kr = clk_en_i & k_s & ~k_s3_q;
   assign knr = clk_en_i & kn_s & ~kn_s3_q;

   // Straps caught once the synchroniser has settled
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         strap_cnt_q <= '0;
         strap_done_q <= 1'b0;
         term_range_high_o <= TERM_RST;
         pll_off_o <= 1'b0;
      end else if (clk_en_i && !strap_done_q) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
         if (strap_cnt_q == STRAP_WAIT) begin
            strap_done_q <= 1'b1;
            term_range_high_o <= term_s | tz_s; // [R2] [R3]
            pll_off_o <= ~pll_disable_pin_n_s; // [R8]
         end
      end
   end

   // Commands only on K rise; full buffer refuses writes
   assign cmd = kr & strap_done_q & ~ld_n_s; // [R4] [R14]
   assign rd_cmd = cmd & rw_s; // [R15]
   assign wr_cmd = cmd & ~rw_s & fifo_rdy; // [R15]

   // Read command history, one step per K rise
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rd_pipe_q <= '0;
         ra0_q <= '0;
         ra1_q <= '0;
      end else if (kr) begin
         rd_pipe_q <= {rd_pipe_q[0], rd_cmd}; // [R5]
         ra1_q <= ra0_q;
         ra0_q <= addr_s[IDX_W-1:0];
      end
   end

   // Write beats: first on next K, second on K-bar
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wr_b0_q <= 1'b0;
         wr_b1_q <= 1'b0;
         wa_q <= '0;
         wa1_q <= '0;
      end else if (kr) begin
         wr_b0_q <= wr_cmd;
         wr_b1_q <= wr_b0_q; // [R16]
         wa1_q <= wa_q;
         if (wr_cmd) begin
            wa_q <= addr_s[IDX_W-1:0];
         end
      end else if (knr) begin
         wr_b1_q <= 1'b0;
      end
   end

   // Data and lane selects taken on either clock rise
   assign push_v = (kr & wr_b0_q) | (knr & wr_b1_q); // [R6] [R12]
   assign push_d = {(knr ? wa1_q : wa_q), knr, bws_n_s, dq_s}; // [R12]

   // Drain pauses on launch cycles so the buffer can back up
   assign pop_rdy = ~(kr | knr);

   bsp_fifo #(
      .WIDTH(WENT_W),
      .DEPTH(FIFO_DEPTH)
   ) bsp_fifo_i (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .clk_en_i(clk_en_i),
      .in_valid_i(push_v),
      .in_ready_o(fifo_rdy),
      .in_data_i(push_d),
      .out_valid_o(pop_v),
      .out_ready_i(pop_rdy),
      .out_data_o(pop_d)
   );

   // Array update, one lane per select
   always_ff @(posedge clock_i) begin
      if (clk_en_i && pop_v && pop_rdy) begin
         for (int l = 0; l < LANES; l++) begin
            if (!pop_d[DATA_W+l]) begin
               mem_q[pop_d[WENT_W-1 -: IDX_W]][pop_d[DATA_W+LANES]][l*LANE_W +: LANE_W] <=
                  pop_d[l*LANE_W +: LANE_W]; // [R17]
            end
         end
      end
   end

   // Read launch; pins float and flag drops without a beat
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pend_b0_kn_q <= 1'b0;
         pend_b1_k_q <= 1'b0;
         pend_b1_kn_q <= 1'b0;
         raddr_q <= '0;
         dq_o <= '0;
         dq_oe_o <= 1'b0;
         read_valid_flag_o <= 1'b0;
      end else if (kr) begin
         pend_b1_k_q <= 1'b0;
         pend_b0_kn_q <= ~pll_off_o & rd_pipe_q[1]; // [R10]
         pend_b1_kn_q <= pll_off_o & rd_pipe_q[0]; // [R16]
         if (!pll_off_o && rd_pipe_q[1]) begin
            raddr_q <= ra1_q;
         end else if (pll_off_o && rd_pipe_q[0]) begin
            raddr_q <= ra0_q;
         end
         if (pend_b1_k_q) begin
            dq_o <= mem_q[raddr_q][1]; // [R5] [R13]
            dq_oe_o <= 1'b1;
            read_valid_flag_o <= 1'b1; // [R1]
         end else if (pll_off_o && rd_pipe_q[0]) begin
            dq_o <= mem_q[ra0_q][0]; // [R11]
            dq_oe_o <= 1'b1;
            read_valid_flag_o <= 1'b1;
         end else begin
            dq_oe_o <= 1'b0; // [R18]
            read_valid_flag_o <= 1'b0; // [R19]
         end
      end else if (knr) begin
         pend_b0_kn_q <= 1'b0;
         pend_b1_kn_q <= 1'b0;
         pend_b1_k_q <= pend_b0_kn_q; // [R16]
         if (pend_b0_kn_q || pend_b1_kn_q) begin
            dq_o <= mem_q[raddr_q][pend_b1_kn_q]; // [R6] [R13]
            dq_oe_o <= 1'b1;
            read_valid_flag_o <= 1'b1; // [R1]
         end else begin
            dq_oe_o <= 1'b0; // [R18]
            read_valid_flag_o <= 1'b0; // [R19]
         end
      end
   end

   // Flag and drivers always move together
   a_valid_with_data: // [R1] [R19]
   assert property (@(posedge clock_i) disable iff (rst_i)
      read_valid_flag_o == dq_oe_o)
   else $error("valid flag differs from drivers");

   // Output enable changes only at a clock rise
   a_dq_on_edges: // [R13]
   assert property (@(posedge clock_i) disable iff (rst_i)
      $changed(dq_oe_o) |-> $past(kr) || $past(knr))
   else $error("drivers moved off a clock rise");

   // Write accepted only at a K rise
   a_cmd_on_k: // [R4]
   assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(wr_b0_q) |-> $past(kr) && !$past(ld_n_s) && !$past(rw_s))
   else $error("write taken off K rise");

   // Long latency: first beat on K-bar rise
   a_lat_long: // [R10]
   assert property (@(posedge clock_i) disable iff (rst_i)
      (kr && !pll_off_o && rd_pipe_q[1]) |-> ##[1:20] (knr && pend_b0_kn_q)
      ##1 (dq_oe_o && dq_o == mem_q[raddr_q][0]))
   else $error("long latency beat missing");

   // Short latency: beat right at next K rise
   a_lat_short: // [R11]
   assert property (@(posedge clock_i) disable iff (rst_i)
      (kr && pll_off_o && rd_pipe_q[0]) |=> dq_oe_o && read_valid_flag_o)
   else $error("short latency beat missing");

   // Idle K rise without pending beat floats pins
   a_float_idle: // [R18]
   assert property (@(posedge clock_i) disable iff (rst_i)
      (kr && !pend_b1_k_q && !(pll_off_o && rd_pipe_q[0])) |=> !dq_oe_o)
   else $error("drivers left on while idle");

   // First beat on a K-bar rise always followed by second
   a_burst_two: // [R16]
   assert property (@(posedge clock_i) disable iff (rst_i)
      (knr && pend_b0_kn_q) |=> pend_b1_k_q && dq_oe_o)
   else $error("second beat not scheduled");

   // Straps frozen after capture
   a_strap_hold: // [R2]
   assert property (@(posedge clock_i) disable iff (rst_i)
      strap_done_q |=> $stable(term_range_high_o) && $stable(pll_off_o))
   else $error("strap changed after capture");

   // Floating range pin reads as high range
   a_float_high: // [R3]
   assert property (@(posedge clock_i) disable iff (rst_i)
      $rose(strap_done_q) && $past(tz_s) |-> term_range_high_o)
   else $error("floating pin not high range");
endmodule : bsp_port

`default_nettype wire

/* bsp_ctrl_model.sv */
// Memory controller model driving clocks, commands and write data
`timescale 1ns/1ps
`default_nettype none
module bsp_ctrl_model (
   output logic k_clk_o,
   output logic k_clk_n_o,
   output logic load_strobe_n_o,
   output logic rw_sel_o,
   output logic [bsp_pkg::ADDR_W-1:0] addr_o,
   output logic [bsp_pkg::LANES-1:0] byte_write_sel_n_o,
   output logic [bsp_pkg::DATA_W-1:0] dq_o
);
   import bsp_pkg::*;
   logic drv = 1'b0;
   // Free-running complementary clocks, 8 MHz, odd start phase
   initial begin
      k_clk_o = 1'b0;
      k_clk_n_o = 1'b1;
      load_strobe_n_o = 1'b1;
      rw_sel_o = 1'b1;
      addr_o = '0;
      byte_write_sel_n_o = 4'hF;
      dq_o = 36'h5A5A5A5A5;
      #3.3;
      forever begin
         #31.25;
         if (!drv) dq_o = ~dq_o; // Released bus never holds its last value
         #31.25;
         k_clk_o = ~k_clk_o;
         k_clk_n_o = ~k_clk_o;
      end
   end
   // Command set up half a cycle ahead of the K rise that takes it
   task automatic cmd(input logic rd, input logic [ADDR_W-1:0] a);
      @(posedge k_clk_n_o);
      load_strobe_n_o = 1'b0;
      rw_sel_o = rd;
      addr_o = a;
      @(posedge k_clk_n_o);
      load_strobe_n_o = 1'b1;
   endtask : cmd
   // Two-beat write: word0 around next K rise, word1 around K-bar rise
   task automatic write_burst(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w0, w1,
                              input logic [LANES-1:0] b0, b1);
      cmd(1'b0, a);
      drv = 1'b1;
      dq_o = w0;
      byte_write_sel_n_o = b0;
      @(posedge k_clk_o);
      #31.25;
      dq_o = w1;
      byte_write_sel_n_o = b1;
      @(posedge k_clk_o);
      #31.25;
      byte_write_sel_n_o = 4'hF;
      drv = 1'b0;
   endtask : write_burst
   // Load low only between K rises, spanning a K-bar rise: must start nothing
   task automatic off_edge_cmd(input logic [ADDR_W-1:0] a);
      @(posedge k_clk_o);
      #20;
      load_strobe_n_o = 1'b0;
      rw_sel_o = 1'b1;
      addr_o = a;
      @(posedge k_clk_n_o);
      #20;
      load_strobe_n_o = 1'b1;
   endtask : off_edge_cmd
endmodule : bsp_ctrl_model
`default_nettype wire

/* bsp_port_tb.sv */
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module bsp_port_tb;
   import bsp_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic ts = 1'b1;
   logic tf = 1'b0;
   logic pn = 1'b1;
   logic run_en = 1'b1;
   logic k, kn, ld_n, rw, oe, vld, ep, en, trh, poff;
   logic [ADDR_W-1:0] a;
   logic [LANES-1:0] bws_n;
   logic [DATA_W-1:0] di, dout;
   logic [DATA_W-1:0] exp_mem [MEM_WORDS][BURST];
   int err_total = 0;
   int total_checks = 0;
   int cyc = 0;
   int ep_rises = 0;
   int en_rises = 0;
   always #4 clock_i = ~clock_i;
   bsp_ctrl_model bsp_ctrl_model_i (.k_clk_o(k), .k_clk_n_o(kn), .load_strobe_n_o(ld_n), .rw_sel_o(rw),
      .addr_o(a), .byte_write_sel_n_o(bws_n), .dq_o(di));
   bsp_port bsp_port_i (.clock_i(clock_i), .rst_i(rst_i), .clk_en_i(run_en), .k_clk_i(k), .k_clk_n_i(kn),
      .load_strobe_n_i(ld_n), .rw_sel_i(rw), .addr_i(a), .byte_write_sel_n_i(bws_n), .dq_i(di),
      .termination_range_select_i(ts), .termination_range_float_i(tf), .pll_disable_pin_n_i(pn),
      .dq_o(dout), .dq_oe_o(oe), .read_valid_flag_o(vld), .echo_out_pos_o(ep), .echo_out_neg_o(en),
      .term_range_high_o(trh), .pll_off_o(poff));
   task automatic test_done;
      $display("Checks made: %0d, mismatches: %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   task automatic check_val(input string n, input logic [DATA_W-1:0] e, g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : check_val
   task automatic check_bit(input string n, input logic e, g);
      total_checks++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask : check_bit
   // Echo rise counters for the free-running check
   always @(posedge ep) ep_rises++;
   always @(posedge en) en_rises++;
   // Hang guard well above the roughly 1060 cycles the run needs
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         test_done();
      end
   end
   task automatic do_reset(input logic t, f, p);
      @(posedge clock_i);
      rst_i <= 1'b1;
      ts <= t;
      tf <= f;
      pn <= p;
      repeat (20) @(posedge clock_i);
      #1;
      check_bit("range in reset", TERM_RST, trh);
      check_bit("oe in reset", 1'b0, oe);
      check_bit("valid in reset", 1'b0, vld);
      @(posedge clock_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge ep);
      #1;
      check_bit("echo neg", 1'b0, en);
      check_bit("range", t | f, trh);
      check_bit("pll off", ~p, poff);
   endtask : do_reset
   // Lanes with a low select take new data, others keep the old byte
   function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] o, n, input logic [LANES-1:0] b);
      for (int l = 0; l < LANES; l++) begin
         if (!b[l]) o[l*LANE_W +: LANE_W] = n[l*LANE_W +: LANE_W];
      end
      return o;
   endfunction : merge
   task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] w0, w1, input logic [LANES-1:0] b0, b1);
      exp_mem[ad[IDX_W-1:0]][0] = merge(exp_mem[ad[IDX_W-1:0]][0], w0, b0);
      exp_mem[ad[IDX_W-1:0]][1] = merge(exp_mem[ad[IDX_W-1:0]][1], w1, b1);
      bsp_ctrl_model_i.write_burst(ad, w0, w1, b0, b1);
   endtask : wr
   // One echo edge later: drivers and flag as expected
   task automatic beat(input logic e);
      @(posedge ep or posedge en);
      #1;
      check_bit("dq oe", e, oe);
      check_bit("valid flag", e, vld);
   endtask : beat
   // Read burst; pre is the count of quiet echo edges before word0
   task automatic rd(input logic [ADDR_W-1:0] ad, input int pre);
      bsp_ctrl_model_i.cmd(1'b1, ad);
      repeat (pre) beat(1'b0);
      beat(1'b1);
      check_val("word0", exp_mem[ad[IDX_W-1:0]][0], dout);
      beat(1'b1);
      check_val("word1", exp_mem[ad[IDX_W-1:0]][1], dout);
      beat(1'b0);
   endtask : rd
   // Idle echoes: 250 clocks span exactly 16 K periods, so 16 rises each
   task automatic echo_free;
      int p0, n0;
      @(posedge clock_i);
      #1;
      p0 = ep_rises;
      n0 = en_rises;
      repeat (250) @(posedge clock_i);
      #1;
      check_val("echo pos rises", DATA_W'(16), DATA_W'(ep_rises - p0));
      check_val("echo neg rises", DATA_W'(16), DATA_W'(en_rises - n0));
   endtask : echo_free
   // Enable low: echoes must stand still although K keeps toggling
   task automatic freeze;
      logic p0, n0, moved;
      moved = 1'b0;
      @(posedge clock_i);
      run_en <= 1'b0;
      @(posedge clock_i);
      #1;
      p0 = ep;
      n0 = en;
      repeat (40) begin
         @(posedge clock_i);
         #1;
         if (ep !== p0 || en !== n0) moved = 1'b1;
      end
      check_bit("echo frozen", 1'b0, moved);
      @(posedge clock_i);
      run_en <= 1'b1;
   endtask : freeze
   // Load low away from K rises: no beat may follow in either mode
   task automatic off_edge(input logic [ADDR_W-1:0] ad);
      bsp_ctrl_model_i.off_edge_cmd(ad);
      repeat (6) beat(1'b0);
   endtask : off_edge
   initial begin
      do_reset(1'b1, 1'b0, 1'b1);
      echo_free();
      freeze();
      wr(21'h3, 36'h123456789, 36'hABCDEF012, 4'h0, 4'h0);
      wr(21'h5, 36'h0F0F0F0F0, 36'h3C3C3C3C3, 4'h0, 4'h0);
      rd(21'h3, 4);
      // Upper address bits alias onto location 5
      rd(21'h10005, 4);
      wr(21'h3, 36'hFEDCBA987, 36'h9A5A5A5A5, 4'h5, 4'hA);
      rd(21'h3, 4);
      off_edge(21'h5);
      do_reset(1'b0, 1'b0, 1'b0);
      wr(21'h7, 36'h111122223, 36'h444455556, 4'h0, 4'h0);
      wr(21'h7, 36'hEEEEEEEEE, 36'hDDDDDDDDD, 4'hE, 4'hF);
      rd(21'h7, 1);
      off_edge(21'h7);
      do_reset(1'b0, 1'b1, 1'b1);
      test_done();
   end
endmodule : bsp_port_tb
`default_nettype wire
